// *** rtl/two_stage_event_controller.sv ***
// Purpose: two-stage event controller: source gating, status, wakeup and
//          routing, then core latch, unmask and nesting of 16 classes.
// Assumes: all event inputs are levels on aclk; pipeline accepts the
//          offered request with a one-cycle accept pulse.
// Notes:   core registers answer only privileged accesses (awprot[0], arprot[0]).
`default_nettype none

module two_stage_event_controller
  import event_ctrl_pkg::*;
#(
  parameter int N_SRC = NUM_SRC
) (
  // clock and reset
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // axi4-lite write address
  input  wire logic                 awvalid,
  output logic                      awready,
  input  wire logic [ADDR_W-1:0]    awaddr,
  input  wire logic [2:0]           awprot,
  // axi4-lite write data
  input  wire logic                 wvalid,
  output logic                      wready,
  input  wire logic [DATA_W-1:0]    wdata,
  input  wire logic [3:0]           wstrb,
  // axi4-lite write response
  output logic                      bvalid,
  input  wire logic                 bready,
  output logic [1:0]                bresp,
  // axi4-lite read address
  input  wire logic                 arvalid,
  output logic                      arready,
  input  wire logic [ADDR_W-1:0]    araddr,
  input  wire logic [2:0]           arprot,
  // axi4-lite read data
  output logic                      rvalid,
  input  wire logic                 rready,
  output logic [DATA_W-1:0]         rdata,
  output logic [1:0]                rresp,
  // peripheral sources and power state
  input  wire logic [N_SRC-1:0]     periph_irq,
  input  wire logic                 powered_down,
  output logic                      wake_req,
  // dedicated core events and instruction strobes
  input  wire core_evt_in_t         core_evt_in,
  input  wire logic                 global_irq_enable_instr,
  input  wire logic                 global_irq_disable_instr,
  // pipeline side
  output evt_req_t                  evt_req,
  input  wire logic                 evt_accept,
  input  wire evt_ret_t             evt_ret,
  output logic [NUM_EVT-1:0]        nesting_out
);

  // two source words per register class are fixed by the map
  if (N_SRC != NUM_SRC) begin : g_bad_src
    $error("N_SRC must equal NUM_SRC");
  end

  // register state
  logic [15:0]                 latch_q;  // [RULE5]
  logic [15:0]                 unmask_q;
  logic [15:0]                 nest_q;
  logic                        gie_q;
  logic [N_SRC-1:0]            src_unmask_q;
  logic [N_SRC-1:0]            wake_en_q;
  logic [N_SRC*ASSIGN_W-1:0]   assign_q;
  logic                        wake_q;

  // edge detection pipeline
  logic [15:0]                 raw_in;
  logic [15:0]                 in_q;
  logic [15:0]                 in_qq;
  logic [15:0]                 edge_hit;
  logic [NUM_GEN-1:0]          gen_level;

  // bus state
  logic                        aw_have_q;
  logic                        w_have_q;
  logic [ADDR_W-1:0]           aw_addr_q;
  logic                        aw_priv_q;
  logic [DATA_W-1:0]           w_data_q;
  logic [3:0]                  w_strb_q;
  logic                        bvalid_q;
  logic [1:0]                  bresp_q;
  logic                        rvalid_q;
  logic [DATA_W-1:0]           rdata_q;
  logic [1:0]                  rresp_q;

  // decode and datapath nets
  logic                        do_write;
  logic [DATA_W-1:0]           wmask;
  logic                        wr_core;
  logic                        wr_ok;
  logic [DATA_W-1:0]           rd_val;
  logic                        rd_ok;
  logic [15:0]                 eff_unmask;
  logic [15:0]                 svc_mask;
  logic [4:0]                  cand;
  logic [4:0]                  act;
  logic                        req_valid;
  logic                        take;
  logic [15:0]                 take_bits;
  logic [15:0]                 ret_bits;
  logic [15:0]                 sw_clr;

  // routing stage: gate, then route onto inputs 7..15
  source_router #(
    .N_SRC        (N_SRC)
  ) u_router (
    .src_gated    (periph_irq & src_unmask_q),        // [RULE13]
    .assign_codes (assign_q),
    .gen_level    (gen_level)
  );

  // all event lines side by side in class order; class 4 has no line
  assign raw_in = {gen_level, core_evt_in.tmr, core_evt_in.hwe, 1'b0,
                   core_evt_in.exc, core_evt_in.nmi, core_evt_in.rst,
                   core_evt_in.emulation_event};

  // two stages give the edge; the second edge makes it latched
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_q  <= 16'h0000;
      in_qq <= 16'h0000;
    end else begin
      in_q  <= raw_in;
      in_qq <= in_q;
    end
  end

  assign edge_hit = in_q & ~in_qq;                    // [RULE17]

  // bus write helpers
  assign do_write = aw_have_q & w_have_q & ~bvalid_q;
  assign wmask    = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}},
                     {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};

  // write address class check; core words need privilege
  always_comb begin
    wr_core = 1'b0;
    wr_ok   = 1'b1;
    case (aw_addr_q)
      OFS_LATCH, OFS_UNMASK, OFS_NEST: begin
        wr_core = 1'b1;
        wr_ok   = aw_priv_q;                          // [RULE7] [RULE9]
      end
      OFS_GIE, OFS_SUNM0, OFS_SUNM1, OFS_SSTAT0, OFS_SSTAT1,
      OFS_WAKE0, OFS_WAKE1: begin
        wr_ok = 1'b1;
      end
      default: begin
        wr_ok = (aw_addr_q[7:5] == ASSIGN_PAGE);
      end
    endcase
  end

  // servicing mask: nonmaskable classes always through
  assign eff_unmask = unmask_q | NONMASK_BITS;
  assign svc_mask   = eff_unmask &
                      (gie_q ? 16'hFFFF : ~GEN_BITS);  // [RULE8] [RULE10]

  // best latched candidate against the highest active nesting level
  assign cand = first_set(latch_q & svc_mask);        // [RULE1]
  assign act  = first_set(nest_q & ~GIE_BIT);
  assign req_valid = cand[4] & (~act[4] | (cand[3:0] < act[3:0]));

  assign evt_req.valid = req_valid;
  assign evt_req.id    = cand[3:0];

  // acceptance turns a latched event into a nested one
  assign take      = req_valid & evt_accept;
  assign take_bits = take ? (16'h0001 << cand[3:0]) : 16'h0000;
  assign ret_bits  = evt_ret.valid ? (16'h0001 << evt_ret.id) : 16'h0000;

  // software cancel: only ones, only where the unmask bit is clear
  assign sw_clr = (do_write && wr_ok && aw_addr_q == OFS_LATCH) ?
                  (w_data_q[15:0] & wmask[15:0] & ~eff_unmask) :
                  16'h0000;                           // [RULE7] [RULE20]

  // latch: a fresh edge wins over any clear in the same cycle;
  // while set, further edges merge and are queued after acceptance
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      latch_q <= 16'h0000;
    end else begin
      latch_q <= (latch_q & ~take_bits & ~sw_clr)     // [RULE6]
                 | edge_hit;                          // [RULE16] [RULE17]
    end
  end

  // nesting: set on acceptance, cleared by the pipeline on return
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nest_q <= 16'h0000;
    end else begin
      nest_q <= (nest_q & ~ret_bits) | take_bits;     // [RULE11] [RULE18]
    end
  end

  assign nesting_out = nest_q;                        // [RULE16]

  // core unmask register, maskable classes only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      unmask_q <= UNMASK_RST;
    end else if (do_write && wr_ok && aw_addr_q == OFS_UNMASK) begin
      unmask_q <= ((unmask_q & ~wmask[15:0]) |
                   (w_data_q[15:0] & wmask[15:0])) & ~NONMASK_BITS;
    end
  end

  // global enable flag; disable wins if both arrive together
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gie_q <= GIE_RST;
    end else if (global_irq_disable_instr) begin
      gie_q <= 1'b0;                                  // [RULE10]
    end else if (global_irq_enable_instr) begin
      gie_q <= 1'b1;                                  // [RULE10]
    end
  end

  // source unmask and wake enable words, byte lanes honoured
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_unmask_q <= {SRC_RST, SRC_RST};
      wake_en_q    <= {SRC_RST, SRC_RST};
    end else if (do_write) begin
      case (aw_addr_q)
        OFS_SUNM0: src_unmask_q[31:0] <=
          (src_unmask_q[31:0] & ~wmask) | (w_data_q & wmask); // [RULE12]
        OFS_SUNM1: src_unmask_q[63:32] <=
          (src_unmask_q[63:32] & ~wmask) | (w_data_q & wmask);
        OFS_WAKE0: wake_en_q[31:0] <=
          (wake_en_q[31:0] & ~wmask) | (w_data_q & wmask);
        OFS_WAKE1: wake_en_q[63:32] <=
          (wake_en_q[63:32] & ~wmask) | (w_data_q & wmask);
        default: begin
        end
      endcase
    end
  end

  // assignment registers; reset gives the default routing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < N_SRC; i++) begin
        assign_q[i*ASSIGN_W +: ASSIGN_W] <=
          default_assign(i);                          // [RULE3] [RULE4]
      end
    end else if (do_write && aw_addr_q[7:5] == ASSIGN_PAGE) begin
      assign_q[aw_addr_q[4:2]*DATA_W +: DATA_W] <=
        (assign_q[aw_addr_q[4:2]*DATA_W +: DATA_W] & ~wmask)
        | (w_data_q & wmask);                         // [RULE2]
    end
  end

  // wake request only while powered down and an enabled source is up
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_q <= 1'b0;
    end else begin
      wake_q <= powered_down & |(periph_irq & wake_en_q); // [RULE15]
    end
  end

  assign wake_req = wake_q;

  // write channels: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= '0;
      aw_priv_q <= 1'b0;
    end else if (awvalid && !aw_have_q) begin
      aw_have_q <= 1'b1;
      aw_addr_q <= awaddr;
      aw_priv_q <= awprot[0];
    end else if (do_write) begin
      aw_have_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= 4'h0;
    end else if (wvalid && !w_have_q) begin
      w_have_q <= 1'b1;
      w_data_q <= wdata;
      w_strb_q <= wstrb;
    end else if (do_write) begin
      w_have_q <= 1'b0;
    end
  end

  // write response; refused writes change nothing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q  <= (wr_ok && !(wr_core && aw_addr_q == OFS_NEST)) ?
                  RESP_OKAY : RESP_SLVERR;            // [RULE11]
    end else if (bready) begin
      bvalid_q <= 1'b0;
    end
  end

  assign awready = ~aw_have_q;
  assign wready  = ~w_have_q;
  assign bvalid  = bvalid_q;
  assign bresp   = bresp_q;

  // read decode; core words answer only privileged reads
  always_comb begin
    rd_val = '0;
    rd_ok  = 1'b1;
    case (araddr)
      OFS_LATCH: begin
        rd_val = {16'h0000, latch_q};
        rd_ok  = arprot[0];                           // [RULE7]
      end
      OFS_UNMASK: begin
        rd_val = {16'h0000, eff_unmask};
        rd_ok  = arprot[0];                           // [RULE9]
      end
      OFS_NEST: begin
        rd_val = {16'h0000, nest_q};
        rd_ok  = arprot[0];                           // [RULE11]
      end
      OFS_GIE:    rd_val = {31'h0000_0000, gie_q};
      OFS_SUNM0:  rd_val = src_unmask_q[31:0];
      OFS_SUNM1:  rd_val = src_unmask_q[63:32];
      OFS_SSTAT0: rd_val = periph_irq[31:0];          // [RULE14]
      OFS_SSTAT1: rd_val = periph_irq[63:32];         // [RULE14]
      OFS_WAKE0:  rd_val = wake_en_q[31:0];
      OFS_WAKE1:  rd_val = wake_en_q[63:32];
      default: begin
        if (araddr[7:5] == ASSIGN_PAGE) begin
          rd_val = assign_q[araddr[4:2]*DATA_W +: DATA_W];
        end else begin
          rd_ok = 1'b0;
        end
      end
    endcase
    if (!rd_ok) rd_val = '0;
  end

  // read channel: one read at a time, answer one edge later
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= '0;
      rresp_q  <= RESP_OKAY;
    end else if (arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_val;
      rresp_q  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign arready = ~rvalid_q;
  assign rvalid  = rvalid_q;
  assign rdata   = rdata_q;
  assign rresp   = rresp_q;

endmodule : two_stage_event_controller

`default_nettype wire

// *** rtl/event_ctrl_pkg.sv ***
// Purpose: shared constants, types and helpers of the two-stage event
//          controller (system routing stage and core event stage).
// Assumes: one clock, AXI4-Lite register access, 64 peripheral sources.
// Notes:   event class bits: 0 emulation, 1 reset, 2 nmi, 3 exception,
//          4 global enable, 5 hardware error, 6 core timer, 7..15 general.
// Behaviour
// RULE1: fixed priority, lowest class number wins, emulation first
// RULE2: assignment registers route each source to one input
// RULE3: default routing for inputs 7, 8 and 9
// RULE4: default routing for inputs 10 to 13
// RULE5: 16-bit latch, unmask and nesting registers
// RULE6: latch sets on capture, clears on acceptance
// RULE7: latch writes privileged, only where unmask bit clear
// RULE8: set unmask bit lets event be serviced
// RULE9: software touches unmask only when privileged
// RULE10: global enable and disable instruction inputs
// RULE11: nesting register hardware-owned, privileged read only
// RULE12: six 32-bit source control and status registers
// RULE13: source unmask bit gates peripheral source through
// RULE14: status bit shows raw source level
// RULE15: enabled source wakes powered-down processor
// RULE16: shared inputs tolerate repeated pulses, nesting acknowledges
// RULE17: rising edge latched in two cycles, requeued after pend
// RULE18: at least three cycles from edge to pending
// RULE19: inputs 14 and 15 left for software handlers
// RULE20: latch write clears ones, leaves zeros alone
`default_nettype none

package event_ctrl_pkg;

  // sizes
  localparam int NUM_EVT  = 16;
  localparam int NUM_GEN  = 9;
  localparam int GEN_BASE = 7;
  localparam int NUM_SRC  = 64;
  localparam int ASSIGN_W = 4;
  localparam int ADDR_W   = 8;
  localparam int DATA_W   = 32;

  // event class bit positions
  localparam int EVT_EMU = 0;
  localparam int EVT_RST = 1;
  localparam int EVT_NMI = 2;
  localparam int EVT_EXC = 3;
  localparam int EVT_GIE = 4;
  localparam int EVT_HWE = 5;
  localparam int EVT_TMR = 6;

  localparam logic [15:0] NONMASK_BITS = 16'h000F;
  localparam logic [15:0] GEN_BITS     = 16'hFF80;
  localparam logic [15:0] GIE_BIT      = 16'h0010;

  // timing figures in core clock cycles
  localparam int EDGE_DETECT_CYC = 2;
  localparam int MIN_PEND_CYC    = 3;

  // register byte offsets
  localparam logic [7:0] OFS_LATCH   = 8'h00;
  localparam logic [7:0] OFS_UNMASK  = 8'h04;
  localparam logic [7:0] OFS_NEST    = 8'h08;
  localparam logic [7:0] OFS_GIE     = 8'h0C;
  localparam logic [7:0] OFS_SUNM0   = 8'h10;
  localparam logic [7:0] OFS_SUNM1   = 8'h14;
  localparam logic [7:0] OFS_SSTAT0  = 8'h18;
  localparam logic [7:0] OFS_SSTAT1  = 8'h1C;
  localparam logic [7:0] OFS_WAKE0   = 8'h20;
  localparam logic [7:0] OFS_WAKE1   = 8'h24;
  localparam logic [2:0] ASSIGN_PAGE = 3'h2;  // 0x40..0x5C

  // reset values
  localparam logic [15:0] UNMASK_RST = 16'h0000;
  localparam logic [31:0] SRC_RST    = 32'h0000_0000;
  localparam logic        GIE_RST    = 1'b0;

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // last source index of each default routing group
  localparam int SRC_END_ERR   = 10;
  localparam int SRC_END_D1    = 21;
  localparam int SRC_END_D2    = 33;
  localparam int SRC_END_TMR   = 45;
  localparam int SRC_END_FLAG  = 51;
  localparam int SRC_END_D1S   = 53;
  localparam int SRC_END_D2S   = 55;
  localparam int SRC_END_IMEM  = 57;
  localparam int SRC_WATCHDOG  = 58;

  // event request towards the pipeline and its return notice
  typedef struct packed {
    logic       valid;
    logic [3:0] id;
  } evt_req_t;

  typedef struct packed {
    logic       valid;
    logic [3:0] id;
  } evt_ret_t;

  // dedicated event lines into the core stage
  typedef struct packed {
    logic emulation_event;
    logic rst;
    logic nmi;
    logic exc;
    logic hwe;
    logic tmr;
  } core_evt_in_t;

  // default assignment code (input number minus 7) of one source
  function automatic logic [3:0] default_assign(input int i);
    if (i <= SRC_END_ERR) return 4'h0;
    else if (i <= SRC_END_D1) return 4'h1;
    else if (i <= SRC_END_D2) return 4'h2;
    else if (i <= SRC_END_TMR) return 4'h3;
    else if (i <= SRC_END_FLAG) return 4'h4;
    else if (i <= SRC_END_D1S) return 4'h1;
    else if (i <= SRC_END_D2S) return 4'h2;
    else if (i <= SRC_END_IMEM) return 4'h5;
    else if (i == SRC_WATCHDOG) return 4'h6;
    else return 4'h0;
  endfunction : default_assign

  // lowest set bit wins, which is the highest priority
  function automatic logic [4:0] first_set(input logic [15:0] v);
    logic [4:0] r;
    r = 5'h00;
    for (int k = NUM_EVT - 1; k >= 0; k--) begin
      if (v[k]) r = {1'b1, 4'(k)};
    end
    return r;
  endfunction : first_set

endpackage : event_ctrl_pkg

`default_nettype wire

// *** rtl/source_router.sv ***
// Purpose: route gated peripheral sources onto the general core inputs.
// Assumes: sources are levels on the core clock.
// Notes:   an assignment code of 9 or more routes the source nowhere.
`default_nettype none

module source_router
  import event_ctrl_pkg::*;
#(
  parameter int N_SRC = NUM_SRC
) (
  // gated source levels
  input  wire logic [N_SRC-1:0]          src_gated,
  // one assignment code per source
  input  wire logic [N_SRC*ASSIGN_W-1:0] assign_codes,
  // levels of general inputs 7..15
  output logic      [NUM_GEN-1:0]        gen_level
);

  // one or-tree per general input; sources sharing it simply merge
  for (genvar g = 0; g < NUM_GEN; g++) begin : g_gen
    logic [N_SRC-1:0] hit;
    for (genvar i = 0; i < N_SRC; i++) begin : g_src
      assign hit[i] = src_gated[i] &
        (assign_codes[i*ASSIGN_W +: ASSIGN_W] == ASSIGN_W'(g)); // [RULE2]
    end
    assign gen_level[g] = |hit;
  end

endmodule : source_router

`default_nettype wire

// *** tb/event_ctrl_props.sv ***
// Purpose: port-level checks of the two-stage event controller.
// Assumes: one clock; reset low disables every check.
// Notes:   checks relate ports only.
`default_nettype none

module event_ctrl_props
  import event_ctrl_pkg::*;
(
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // register bus
  input wire logic        awready,
  input wire logic        wready,
  input wire logic        bvalid,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [7:0]  araddr,
  input wire logic [2:0]  arprot,
  input wire logic        rvalid,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  // power and pipeline
  input wire logic        powered_down,
  input wire logic        wake_req,
  input wire evt_req_t    evt_req,
  input wire logic        evt_accept,
  input wire evt_ret_t    evt_ret,
  input wire logic [15:0] nesting_out
);
  logic [31:0] upto;
  logic        took;
  logic        core_rd;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // classes 0..id; any of them nested must hold the request back
  assign upto    = (32'h2 << evt_req.id) - 32'h1;
  assign took    = evt_req.valid && evt_accept;
  assign core_rd = arvalid && arready && araddr < OFS_GIE;

  prio_order_a:
    assert property (evt_req.valid |->
      (nesting_out & ~GIE_BIT & upto[15:0]) == 16'h0)
    else $error("request while same or higher class nested");
  accept_nest_a:
    assert property (took |=> nesting_out[$past(evt_req.id)])
    else $error("accepted event not nested");
  ret_clear_a:
    assert property (evt_ret.valid && !took |=>
      !nesting_out[$past(evt_ret.id)])
    else $error("return left nesting bit set");
  nest_hold_a:
    assert property (!took && !evt_ret.valid |=> $stable(nesting_out))
    else $error("nesting changed without accept or return");
  wake_cause_a:
    assert property (wake_req |-> $past(powered_down))
    else $error("wake while not powered down");
  wake_off_a:
    assert property (!powered_down |=> !wake_req)
    else $error("wake held after power up");
  rd_answer_a:
    assert property (arvalid && arready |=> rvalid)
    else $error("read data late");
  rd_priv_a:
    assert property (core_rd && !arprot[0] |=>
      rresp == RESP_SLVERR && rdata == 32'h0)
    else $error("core register read without privilege");
  rd_narrow_a:
    assert property (core_rd |=> rdata[31:16] == 16'h0)
    else $error("core register upper half not zero");
  wr_answer_a:
    assert property ($rose(bvalid) |-> $past(!awready && !wready))
    else $error("write answered before both parts taken");

  took_c:   cover property (took);
  wake_c:   cover property (wake_req);
  refuse_c: cover property (rvalid && rresp == RESP_SLVERR);
endmodule : event_ctrl_props

bind two_stage_event_controller event_ctrl_props event_ctrl_props_i (.*);

`default_nettype wire

// *** tb/pipeline_model.sv ***
// Purpose: pipeline stand-in that accepts offered event requests.
// Assumes: accept counts only while a request is offered.
// Notes:   lag delays acceptance so others can latch.
`default_nettype none

module pipeline_model
  import event_ctrl_pkg::*;
(
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // request and answer
  input  wire evt_req_t   evt_req,
  input  wire logic [3:0] lag,
  output logic            evt_accept
);
  logic [3:0] wait_q;

  // cycles the current request has waited
  always_ff @(posedge aclk) begin
    if (!aresetn || !evt_req.valid || evt_accept)
      wait_q <= 4'h0;
    else
      wait_q <= wait_q + 4'h1;
  end

  // never accept an empty offer, as a real pipeline would not
  assign evt_accept = evt_req.valid && (wait_q >= lag);
endmodule : pipeline_model

`default_nettype wire

// *** tb/testbench.sv ***
// Purpose: self-checking bench of the two-stage event controller.
// Assumes: 40 MHz aclk; bench acts as register master, privileged except in the refusal cases.
// Notes:   source 34 is used for routing, gating and cancel cases.
`default_nettype none
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin \
  n_mismatch++; $display("FAIL %s exp %0h got %0h", nm, e, g); end end

module testbench
  import event_ctrl_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic aclk = 1'b0, aresetn = 1'b0, powered_down = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1;
  logic arvalid = 1'b0, rready = 1'b1;
  logic [7:0] awaddr = 8'h0, araddr = 8'h0;
  logic [2:0] awprot = 3'h0, arprot = 3'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF, lag = 4'h0;
  logic [63:0] periph_irq = 64'h0;
  logic global_irq_enable_instr = 1'b0, global_irq_disable_instr = 1'b0;
  core_evt_in_t core_evt_in = 6'h0;
  evt_ret_t evt_ret = 5'h0;
  logic awready, wready, bvalid, arready, rvalid, wake_req, evt_accept;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] nesting_out;
  evt_req_t evt_req;
  int n_mismatch = 0, cmp_count = 0;

  two_stage_event_controller two_stage_event_controller_i (.*);
  pipeline_model pipeline_model_i (.*);

  always #12.5 aclk = ~aclk;

  // write both channels at once, release each when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic p, input logic [1:0] er);
    bit ap = 1'b1;
    bit wp = 1'b1;
    awaddr <= a;
    awprot <= {2'b00, p};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (ap || wp) begin
      @(posedge aclk);
      if (ap && awready === 1'b1) begin
        ap = 1'b0;
        awvalid <= 1'b0;
      end
      if (wp && wready === 1'b1) begin
        wp = 1'b0;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    `CHK("bresp", er, bresp)
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic p,
                    input logic [31:0] ed, input logic [1:0] er);
    araddr <= a;
    arprot <= {2'b00, p};
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    `CHK("rdata", ed, rdata)
    `CHK("rresp", er, rresp)
  endtask : rd

  // edges from stimulus to nesting bit, bounded
  task automatic nest_wait(input int b, input int lo);
    int n = 0;
    do begin
      @(posedge aclk);
      #1;
      n++;
    end while (nesting_out[b] !== 1'b1 && n < 20);
    @(posedge aclk);
    `CHK("nesting bit", 1'b1, nesting_out[b])
    `CHK("latency floor", 1'b1, n >= lo)
  endtask : nest_wait

  task automatic ret(input logic [3:0] id);
    evt_ret <= {1'b1, id};
    @(posedge aclk);
    evt_ret <= 5'h0;
  endtask : ret

  task automatic t_reset();
    logic [31:0] dflt [8] = '{32'h0, 32'h11111000, 32'h22111111,
      32'h22222222, 32'h33333322, 32'h44333333, 32'h22114444,
      32'h00000655};
    rd(OFS_UNMASK, 1'b1, 32'hF, RESP_OKAY);
    rd(OFS_LATCH, 1'b1, 32'h0, RESP_OKAY);
    rd(OFS_SUNM0, 1'b1, 32'h0, RESP_OKAY);
    rd(OFS_WAKE1, 1'b1, 32'h0, RESP_OKAY);
    for (int k = 0; k < 8; k++)
      rd(8'h40 + 8'(4 * k), 1'b1, dflt[k], RESP_OKAY);
  endtask : t_reset

  task automatic t_refuse();
    rd(OFS_LATCH, 1'b0, 32'h0, RESP_SLVERR);
    rd(8'h30, 1'b1, 32'h0, RESP_SLVERR);
    wr(OFS_NEST, 32'hFFFF, 1'b1, RESP_SLVERR);
    wr(OFS_UNMASK, 32'hFFFF, 1'b0, RESP_SLVERR);
    rd(OFS_UNMASK, 1'b1, 32'hF, RESP_OKAY);
  endtask : t_refuse

  task automatic t_route();
    wr(OFS_SUNM1, 32'h4, 1'b1, RESP_OKAY);
    wr(OFS_UNMASK, 32'h0500, 1'b1, RESP_OKAY);
    global_irq_enable_instr <= 1'b1;
    @(posedge aclk);
    global_irq_enable_instr <= 1'b0;
    rd(OFS_GIE, 1'b1, 32'h1, RESP_OKAY);
    periph_irq[34] <= 1'b1;
    nest_wait(10, MIN_PEND_CYC);
    rd(OFS_SSTAT1, 1'b1, 32'h4, RESP_OKAY);
    rd(OFS_NEST, 1'b1, 32'h0400, RESP_OKAY);
    rd(OFS_LATCH, 1'b1, 32'h0, RESP_OKAY);
    periph_irq[34] <= 1'b0;
    ret(4'hA);
    rd(OFS_SSTAT1, 1'b1, 32'h0, RESP_OKAY);
    // move source 34 to input 8
    wr(8'h50, 32'h33333122, 1'b1, RESP_OKAY);
    periph_irq[34] <= 1'b1;
    nest_wait(8, MIN_PEND_CYC);
    periph_irq[34] <= 1'b0;
    ret(4'h8);
  endtask : t_route

  task automatic t_gate();
    global_irq_disable_instr <= 1'b1;
    @(posedge aclk);
    global_irq_disable_instr <= 1'b0;
    periph_irq[34] <= 1'b1;
    repeat (6) @(posedge aclk);
    `CHK("held back", 16'h0, nesting_out)
    rd(OFS_LATCH, 1'b1, 32'h0100, RESP_OKAY);
    wr(OFS_LATCH, 32'h0100, 1'b1, RESP_OKAY);
    rd(OFS_LATCH, 1'b1, 32'h0100, RESP_OKAY);
    wr(OFS_UNMASK, 32'h0400, 1'b1, RESP_OKAY);
    wr(OFS_LATCH, 32'h0200, 1'b1, RESP_OKAY);
    rd(OFS_LATCH, 1'b1, 32'h0100, RESP_OKAY);
    wr(OFS_LATCH, 32'h0100, 1'b1, RESP_OKAY);
    rd(OFS_LATCH, 1'b1, 32'h0, RESP_OKAY);
    periph_irq[34] <= 1'b0;
  endtask : t_gate

  // nmi and exception together, pipeline slow so both latch
  task automatic t_prio();
    lag <= 4'h3;
    core_evt_in <= 6'h0C;
    nest_wait(2, MIN_PEND_CYC);
    `CHK("first nested", 16'h0004, nesting_out)
    core_evt_in <= 6'h0;
    ret(4'h2);
    nest_wait(3, 1);
    ret(4'h3);
    lag <= 4'h0;
  endtask : t_prio

  task automatic t_wake();
    wr(OFS_WAKE0, 32'h1, 1'b1, RESP_OKAY);
    powered_down <= 1'b1;
    periph_irq[1] <= 1'b1;
    repeat (3) @(posedge aclk);
    `CHK("wake off", 1'b0, wake_req)
    periph_irq[0] <= 1'b1;
    repeat (3) @(posedge aclk);
    `CHK("wake on", 1'b1, wake_req)
    powered_down <= 1'b0;
    periph_irq[1:0] <= 2'h0;
  endtask : t_wake

  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : close_out

  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_refuse();
    t_route();
    t_gate();
    t_prio();
    t_wake();
    close_out();
  end

  // tests need under 1000 cycles; this cuts any hang
  initial begin
    repeat (5000) @(posedge aclk);
    n_mismatch++;
    close_out();
  end
endmodule : testbench

`default_nettype wire
